// ---- tb/sram_ctl_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------
// Controller write data driver
// ----------------------------------------
module sram_ctl_model #(
    parameter int LANES = 4
) (
    input wire logic clk_sys,
    input wire logic clock_hold_n,
    input wire logic data_due,
    input wire logic [LANES*9-1:0] wr_word,
    output logic [LANES*8-1:0] data_in,
    output logic [LANES-1:0] parity_lanes_in
);
    logic [1:0] due_reg = 2'b00;
    logic [LANES*9-1:0] w1_reg;
    logic [LANES*9-1:0] w2_reg;

    initial {parity_lanes_in, data_in} = '0;

    // Data trails its address by two qualified edges; a held edge moves nothing
    always @(posedge clk_sys) begin
        if (!clock_hold_n) begin
            due_reg <= {due_reg[0], data_due};
            w1_reg <= wr_word;
            w2_reg <= w1_reg;
        end
    end

    // Drive only in the data slot; elsewhere toggle so stale data never passes as a match
    always @(posedge clk_sys) begin
        #1;
        if (due_reg[1]) begin
            {parity_lanes_in, data_in} <= w2_reg;
        end else begin
            {parity_lanes_in, data_in} <= ~{parity_lanes_in, data_in};
        end
    end
endmodule

// ---- tb/sram_cycle_properties.sv ----
`timescale 1ns/100ps
`include "sram_cfg.svh"

// ----------------------------------------
// Cycle decode properties
// ----------------------------------------
module sram_cycle_properties
    import sram_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int LANES = `SRAM_LANES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire chip_sel_t chip_sel,
    input wire logic advance_or_load,
    input wire logic write_n,
    input wire logic clock_hold_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [LANES*`SRAM_BYTE_W-1:0] data_out,
    input wire logic lanes_oe,
    input wire logic asleep
);
    logic sel;
    logic go;

    // Full select and a qualified edge; a held or sleeping edge moves nothing
    assign sel = !chip_sel.sel1_n && chip_sel.sel2 && !chip_sel.sel3_n;
    assign go = !clock_hold_n && !asleep;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    AST_RST_IDLE: assert property ($rose(nrst) |-> !lanes_oe && !asleep)
        else $error("drive or sleep after reset");
    AST_OE_GATE: assert property (lanes_oe |-> !output_enable_n)
        else $error("drive without output enable");
    AST_SLEEP_TRI: assert property (asleep |-> !lanes_oe)
        else $error("drive while asleep");
    AST_RD_DRIVE: assert property (go && sel && !advance_or_load && write_n ##1 go [*2]
        |=> lanes_oe == (!output_enable_n && !asleep)) else $error("read drive wrong");
    AST_WR_TRI: assert property (go && sel && !advance_or_load && !write_n ##1 go [*2]
        |=> !lanes_oe) else $error("write cycle drives");
    AST_DESEL: assert property (go && !sel && !advance_or_load ##1 go [*2] |=> !lanes_oe)
        else $error("deselect drives");
    AST_HOLD: assert property (clock_hold_n && !asleep |=> $stable(data_out) || asleep)
        else $error("held edge moved data");
    AST_SLEEP_IN: assert property (sleep_request [*2] |=> asleep)
        else $error("sleep entry late");
    AST_SLEEP_OUT: assert property ($fell(sleep_request) && asleep ##1 !sleep_request
        |-> asleep ##1 !asleep) else $error("sleep exit not two cycles");

    cover property (go && sel && !advance_or_load && write_n && !output_enable_n);
    cover property (clock_hold_n && lanes_oe);
    cover property (asleep);
endmodule

bind sync_burst_sram sram_cycle_properties #(.ADDR_W(ADDR_W), .LANES(LANES)) u_props (.clk_sys, .nrst,
    .chip_sel, .advance_or_load, .write_n, .clock_hold_n, .output_enable_n, .sleep_request, .data_out,
    .lanes_oe, .asleep);

// ---- tb/tb_sync_burst_sram.sv ----
`timescale 1ns/100ps

// ----------------------------------------
// Cycle decode bench
// ----------------------------------------
module tb_sync_burst_sram
    import sram_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    chip_sel_t chip_sel = 3'b000;
    logic advance_or_load = 1'b0;
    logic write_n = 1'b1;
    logic [3:0] byte_lane_write_n = 4'hf;
    logic clock_hold_n = 1'b0;
    logic output_enable_n = 1'b0;
    logic sleep_request = 1'b0;
    logic burst_interleaved = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] data_in;
    logic [3:0] parity_lanes_in;
    logic [31:0] data_out;
    logic [3:0] parity_lanes_out;
    logic lanes_oe;
    logic asleep;
    logic data_due = 1'b0;
    logic [35:0] dat = '0;
    logic [35:0] mem [64];
    logic [35:0] pdat [3];
    logic [2:0] prd = 3'b000;
    logic [1:0] kind = 2'h0;
    logic [5:0] base = 6'h00;
    logic [1:0] beat = 2'h0;
    logic mode = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int nseq = 0;

    sync_burst_sram #(.ADDR_W(6), .LANES(4)) DUT (.clk_sys, .nrst, .chip_sel, .advance_or_load, .write_n,
        .byte_lane_write_n, .clock_hold_n, .output_enable_n, .sleep_request, .burst_interleaved, .addr,
        .data_in, .parity_lanes_in, .data_out, .parity_lanes_out, .lanes_oe, .asleep);
    sram_ctl_model #(.LANES(4)) ctl (.clk_sys, .clock_hold_n, .data_due, .wr_word(dat), .data_in,
        .parity_lanes_in);

    always #2 clk_sys = ~clk_sys;

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Generous ceiling; the planned run is about 150 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            test_done;
        end
    end

    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({35'h0, got}, {35'h0, exp});
    endtask

    // One bus cycle; the model keeps burst state and a three-deep expected output pipe
    task automatic cyc(input chip_sel_t cs, input logic adv, input logic wn, input logic [3:0] ln,
            input logic [5:0] a, input logic il, input logic oe_n, input logic run);
        logic [5:0] ad;
        nseq++;
        dat = {nseq[3:0], {4{nseq[7:0]}} ^ 32'h5a3c_0f96};
        chip_sel = cs;
        advance_or_load = adv;
        write_n = wn;
        byte_lane_write_n = ln;
        addr = a;
        burst_interleaved = il;
        output_enable_n = oe_n;
        clock_hold_n = !run;
        if (run) begin
            if (!adv) begin
                kind = (cs !== 3'b010) ? 2'h0 : (wn ? 2'h1 : 2'h2);
                base = a;
                beat = 2'h0;
                mode = il;
            end else begin
                beat = beat + 2'h1;
            end
            ad = {base[5:2], mode ? base[1:0] ^ beat : base[1:0] + beat};
            for (int i = 0; i < 4; i++) begin
                if (kind == 2'h2 && !ln[i]) begin
                    mem[ad][8*i+:8] = dat[8*i+:8];
                    mem[ad][32+i] = dat[32+i];
                end
            end
            prd = {prd[1:0], kind == 2'h1};
            pdat[2] = pdat[1];
            pdat[1] = pdat[0];
            pdat[0] = mem[ad];
        end
        data_due = run && kind == 2'h2;
        @(posedge clk_sys);
        #1;
        chk_bit(lanes_oe, prd[2] && !oe_n);
        if (prd[2] && !oe_n) chk_word({parity_lanes_out, data_out}, pdat[2]);
    endtask

    task automatic burst(input logic wn, input logic [5:0] a, input int n, input logic il,
            input logic [15:0] lw, input logic oe_n);
        for (int j = 0; j < n; j++) cyc(3'b010, j != 0, wn, lw[4*(j%4)+:4], a, il, oe_n, 1'b1);
    endtask

    task automatic idle(input int k);
        repeat (k) cyc(3'b000, 1'b0, 1'b1, 4'h0, 6'h00, 1'b0, 1'b0, 1'b1);
    endtask

    // Main sequence; output enable stays low except in the first write pass, the dummy read burst and odd beats at 6'h11
    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        chk_bit(lanes_oe, 1'b0);
        nrst = 1'b1;
        chk_bit(asleep, 1'b0);
        for (int a = 0; a < 64; a += 4) burst(1'b0, 6'(a), 4, 1'b0, 16'h0000, 1'b1);
        burst(1'b1, 6'h06, 5, 1'b0, 16'h0000, 1'b0);
        for (int m = 0; m < 4; m++) begin
            burst(1'b0, 6'(9 + 4 * m), 4, 1'b1, 16'hfedc - 16'(m * 16'h4444), 1'b0);
            burst(1'b1, 6'(9 + 4 * m), 4, 1'b1, 16'h0000, 1'b0);
        end
        burst(1'b0, 6'h20, 2, 1'b0, 16'hffff, 1'b0);
        burst(1'b1, 6'h20, 2, 1'b0, 16'h0000, 1'b0);
        burst(1'b1, 6'h06, 4, 1'b0, 16'h0000, 1'b1);
        for (int j = 0; j < 6; j++) cyc(3'b010, j != 0, 1'b1, 4'h0, 6'h11, 1'b0, j[0], 1'b1);
        for (int i = 0; i < 3; i++) cyc(3'b010 ^ 3'(1 << i), 1'b0, 1'b1, 4'h0, 6'h06, 1'b0, 1'b0, 1'b1);
        cyc(3'b010, 1'b1, 1'b1, 4'h0, 6'h06, 1'b0, 1'b0, 1'b1);
        idle(2);
        burst(1'b1, 6'h0c, 3, 1'b0, 16'h0000, 1'b0);
        repeat (2) cyc(3'b010, 1'b1, 1'b1, 4'h0, 6'h00, 1'b0, 1'b0, 1'b0);
        cyc(3'b010, 1'b1, 1'b1, 4'h0, 6'h00, 1'b0, 1'b0, 1'b1);
        idle(3);
        sleep_request = 1'b1;
        idle(1);
        chk_bit(asleep, 1'b0);
        idle(1);
        chk_bit(asleep, 1'b1);
        idle(2);
        sleep_request = 1'b0;
        idle(1);
        chk_bit(asleep, 1'b1);
        idle(1);
        chk_bit(asleep, 1'b0);
        burst(1'b1, 6'h09, 4, 1'b1, 16'h0000, 1'b0);
        idle(3);
        test_done;
    end
endmodule

// ---- verilog/burst_step.sv ----
`timescale 1ns/100ps

// ----------------------------------------
// Burst address step: low address bits for the n-th beat
// ----------------------------------------
module burst_step
    import sram_pkg::*;
(
    input wire logic [`SRAM_BURST_W-1:0] start_bits,
    input wire logic [`SRAM_BURST_W-1:0] beat,
    input wire logic interleaved,
    output logic [`SRAM_BURST_W-1:0] bits
);

    // Linear order adds and wraps; interleaved order flips bits
    function automatic logic [`SRAM_BURST_W-1:0] step_bits(
        input logic [`SRAM_BURST_W-1:0] s,
        input logic [`SRAM_BURST_W-1:0] n,
        input logic il
    );
        step_bits = il ? (s ^ n) : `SRAM_BURST_W'(s + n);
    endfunction

    // Pure decode, registered by the caller
    always_comb begin
        bits = step_bits(start_bits, beat, interleaved);
    end

endmodule

// ---- verilog/lane_memory.sv ----
`timescale 1ns/100ps

// ----------------------------------------
// Lane-writable storage with registered read data
// ----------------------------------------
module lane_memory
    import sram_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int LANES = `SRAM_LANES,
    parameter int LANE_W = `SRAM_BYTE_W + 1
) (
    input wire logic clk_sys,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [LANES*LANE_W-1:0] rd_data,
    input wire logic [LANES-1:0] wr_lane,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [LANES*LANE_W-1:0] wr_data
);

    logic [LANES*LANE_W-1:0] store [0:(1<<ADDR_W)-1];
    logic [LANES*LANE_W-1:0] rd_data_reg;
    logic [LANES*LANE_W-1:0] rd_data_next;

    // Same-edge write to the read address is forwarded lane by lane,
    // so a read right behind a write sees the new bytes
    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_en) begin
            rd_data_next = store[rd_addr];
            for (int i = 0; i < LANES; i++) begin
                if (wr_lane[i] && (wr_addr == rd_addr)) begin
                    rd_data_next[i*LANE_W +: LANE_W] = wr_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Storage has no reset; contents are undefined at power-up
    always_ff @(posedge clk_sys) begin
        rd_data_reg <= rd_data_next;
        for (int i = 0; i < LANES; i++) begin
            if (wr_lane[i]) begin
                store[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end
        end
    end

    assign rd_data = rd_data_reg;

endmodule

// ---- verilog/sram_cfg.svh ----
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH

// ----------------------------------------
// Geometry defaults
// ----------------------------------------
`define SRAM_ADDR_W 19
`define SRAM_LANES 4
`define SRAM_MAX_LANES 4
`define SRAM_BYTE_W 8
`define SRAM_BURST_W 2

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define SRAM_SLEEP_SYNC_STAGES 2
`define SRAM_LANES_RST 4'h0
`define SRAM_COUNT_RST 2'h0

`endif

// ---- verilog/sram_pkg.sv ----
`include "sram_cfg.svh"

package sram_pkg;

    // Kind of access held in one pipeline stage
    typedef enum logic [1:0] {
        CYC_NONE = 2'b00,
        CYC_READ = 2'b01,
        CYC_WRITE = 2'b10
    } cyc_kind_t;

    // Control carried down the pipeline with each access
    typedef struct packed {
        cyc_kind_t kind;
        logic [`SRAM_MAX_LANES-1:0] lanes;
    } stage_ctl_t;

    // Chip selects that travel together from the controller
    typedef struct packed {
        logic sel1_n;
        logic sel2;
        logic sel3_n;
    } chip_sel_t;

endpackage

// ---- verilog/sync_burst_sram.sv ----
`timescale 1ns/100ps

// Function
// - Load with a select inactive: deselect, tri-state
// - Load, selected, write high: start read burst
// - Advance during read: ignore selects, next address
// - Output enable off at start: dummy read
// - Output enable off on continuation: dummy read
// - Load, selected, write low, lane low: write
// - Advance during write: next address, low lanes
// - Write start, no lanes: burst starts, nothing written
// - Write continuation, no lanes: advance, no write
// - Clock hold high: edge ignored, state kept
// - Write cycle in output stage: lanes tri-stated
// - Lane drive follows output stage and enable
// - Power-up deselected, lanes tri-stated
// - Output enable acts unclocked, masked in writes
// - Reads drive only when enabled and selected
// - Any lane mask valid; lane includes parity
// - Write high ignores lanes; no lanes writes nothing
// - Narrow build has two lane selects only
// - Sleep overrides everything, lanes tri-stated
// - Sleep entry and exit take two cycles
// - Four-beat burst, linear or interleaved, wraps
// - Write data taken two edges after address
module sync_burst_sram
    import sram_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int LANES = `SRAM_LANES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire chip_sel_t chip_sel,
    input wire logic advance_or_load,
    input wire logic write_n,
    input wire logic [LANES-1:0] byte_lane_write_n,
    input wire logic clock_hold_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_interleaved,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES*`SRAM_BYTE_W-1:0] data_in,
    input wire logic [LANES-1:0] parity_lanes_in,
    output logic [LANES*`SRAM_BYTE_W-1:0] data_out,
    output logic [LANES-1:0] parity_lanes_out,
    output logic lanes_oe,
    output logic asleep
);

    localparam int LANE_W = `SRAM_BYTE_W + 1;
    localparam int WORD_W = LANES * LANE_W;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Only the wide four-lane and narrow two-lane builds exist
    if (!((LANES == 2) || (LANES == 4))) begin : g_lane_check
        $error("LANES must be 2 or 4");
    end
    if (ADDR_W < `SRAM_BURST_W) begin : g_addr_check
        $error("ADDR_W too small for the burst counter");
    end
    // The stage flags hold at most the wide build's lane count
    if (LANES > `SRAM_MAX_LANES) begin : g_flag_check
        $error("LANES exceeds the stage lane flags");
    end

    // ----------------------------------------
    // Sleep request synchroniser
    // ----------------------------------------
    logic sleep_meta_reg;
    logic sleep_meta_next;
    logic sleep_reg;
    logic sleep_next;

    // Asynchronous pin: two flops, which also gives the two-cycle entry
    always_comb begin
        sleep_meta_next = sleep_request;
        sleep_next = sleep_meta_reg;
    end

    // Reset clears both flops, so a request already high at release
    // still needs two edges before any access is dropped
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sleep_meta_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_meta_next;
            sleep_reg <= sleep_next;
        end
    end

    // ----------------------------------------
    // Input decode
    // ----------------------------------------
    logic all_sel;
    logic step_en;
    logic [LANES-1:0] lane_sel;
    logic [`SRAM_MAX_LANES-1:0] lane_sel_wide;

    // Edges are qualified by clock hold and dropped entirely in sleep;
    // the hold pin stalls while high, so a low level lets edges through
    assign step_en = !clock_hold_n && !sleep_reg;
    assign all_sel = !chip_sel.sel1_n && chip_sel.sel2 && !chip_sel.sel3_n;
    assign lane_sel = ~byte_lane_write_n;
    assign lane_sel_wide = `SRAM_MAX_LANES'(lane_sel);

    // ----------------------------------------
    // Burst state
    // ----------------------------------------
    cyc_kind_t burst_kind_reg;
    cyc_kind_t burst_kind_next;
    logic [ADDR_W-1:0] base_reg;
    logic [ADDR_W-1:0] base_next;
    logic [`SRAM_BURST_W-1:0] beat_reg;
    logic [`SRAM_BURST_W-1:0] beat_next;
    logic [`SRAM_BURST_W-1:0] beat_inc;
    logic interleaved_reg;
    logic interleaved_next;
    logic [`SRAM_BURST_W-1:0] step_bits;

    // Next beat is formed outside the state process so the step decode
    // never feeds back into the process that uses it
    assign beat_inc = `SRAM_BURST_W'(beat_reg + 1'b1);

    burst_step u_step (
        .start_bits(base_reg[`SRAM_BURST_W-1:0]),
        .beat(beat_inc),
        .interleaved(interleaved_reg),
        .bits(step_bits)
    );

    // Stage one: the access taken at this edge
    stage_ctl_t s1_reg;
    stage_ctl_t s1_next;
    logic [ADDR_W-1:0] s1_addr_reg;
    logic [ADDR_W-1:0] s1_addr_next;

    // Load takes the pin address; advance ignores selects and write
    // select and steps the counter, wrapping after four beats
    always_comb begin
        burst_kind_next = burst_kind_reg;
        base_next = base_reg;
        beat_next = beat_reg;
        interleaved_next = interleaved_reg;
        s1_next = s1_reg;
        s1_addr_next = s1_addr_reg;
        if (step_en) begin
            if (!advance_or_load) begin
                beat_next = `SRAM_COUNT_RST;
                base_next = addr;
                interleaved_next = burst_interleaved;
                s1_addr_next = addr;
                s1_next.lanes = `SRAM_LANES_RST;
                if (!all_sel) begin
                    burst_kind_next = CYC_NONE;
                end else if (write_n) begin
                    burst_kind_next = CYC_READ;
                end else begin
                    // A start with every lane high still loads the base so the
                    // next beats step from it, but no lane flag is set to write
                    burst_kind_next = CYC_WRITE;
                    s1_next.lanes = lane_sel_wide;
                end
                s1_next.kind = burst_kind_next;
            end else begin
                beat_next = beat_inc;
                s1_addr_next = {base_reg[ADDR_W-1:`SRAM_BURST_W], step_bits};
                s1_next.kind = burst_kind_reg;
                // Lane selects are sampled afresh on every beat
                s1_next.lanes = (burst_kind_reg == CYC_WRITE) ? lane_sel_wide
                                                              : `SRAM_LANES_RST;
            end
        end else if (sleep_reg) begin
            // Pending accesses are dropped when sleep takes hold
            // Base and beat are kept; the first access after sleep is a load
            burst_kind_next = CYC_NONE;
            s1_next.kind = CYC_NONE;
            s1_next.lanes = `SRAM_LANES_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            burst_kind_reg <= CYC_NONE;
            base_reg <= '0;
            beat_reg <= `SRAM_COUNT_RST;
            interleaved_reg <= 1'b0;
            s1_reg <= '{kind: CYC_NONE, lanes: `SRAM_LANES_RST};
            s1_addr_reg <= '0;
        end else begin
            burst_kind_reg <= burst_kind_next;
            base_reg <= base_next;
            beat_reg <= beat_next;
            interleaved_reg <= interleaved_next;
            s1_reg <= s1_next;
            s1_addr_reg <= s1_addr_next;
        end
    end

    // ----------------------------------------
    // Stage two and output stage
    // ----------------------------------------
    stage_ctl_t s2_reg;
    stage_ctl_t s2_next;
    logic [ADDR_W-1:0] s2_addr_reg;
    logic [ADDR_W-1:0] s2_addr_next;
    logic drive_reg;
    logic drive_next;
    logic [WORD_W-1:0] out_reg;
    logic [WORD_W-1:0] out_next;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] wr_word;
    logic [LANES-1:0] wr_lane;
    logic rd_en;

    // Read is issued from stage one whether or not output enable is on,
    // so a dummy read still moves the burst and fetches the word;
    // a held edge leaves the read register alone, so the word waits
    assign rd_en = step_en && (s1_reg.kind == CYC_READ);

    // Write data is taken one edge after stage two, two after the address
    assign wr_lane = (step_en && (s2_reg.kind == CYC_WRITE)) ? s2_reg.lanes[LANES-1:0]
                                                             : '0;

    // Each lane pairs its data byte with its parity bit
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            wr_word[i*LANE_W +: LANE_W] = {parity_lanes_in[i], data_in[i*`SRAM_BYTE_W +: `SRAM_BYTE_W]};
        end
    end

    lane_memory #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(LANE_W)
    ) u_mem (
        .clk_sys(clk_sys),
        .rd_en(rd_en),
        .rd_addr(s1_addr_reg),
        .rd_data(rd_word),
        .wr_lane(wr_lane),
        .wr_addr(s2_addr_reg),
        .wr_data(wr_word)
    );

    // The drive flag follows the kind entering the output stage, so a
    // write there tri-states all lanes even for a partial byte write
    always_comb begin
        s2_next = s2_reg;
        s2_addr_next = s2_addr_reg;
        drive_next = drive_reg;
        out_next = out_reg;
        if (step_en) begin
            s2_next = s1_reg;
            s2_addr_next = s1_addr_reg;
            drive_next = (s2_reg.kind == CYC_READ);
            out_next = rd_word;
        end else if (sleep_reg) begin
            // Output stage empties so nothing drives when sleep ends
            s2_next = '{kind: CYC_NONE, lanes: `SRAM_LANES_RST};
            drive_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s2_reg <= '{kind: CYC_NONE, lanes: `SRAM_LANES_RST};
            s2_addr_reg <= '0;
            drive_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            s2_reg <= s2_next;
            s2_addr_reg <= s2_addr_next;
            drive_reg <= drive_next;
            out_reg <= out_next;
        end
    end

    // ----------------------------------------
    // Lane drivers
    // ----------------------------------------
    // Output enable gates the drivers without a clock edge; this enable
    // is the one output not taken straight from a flop, since sampling
    // the enable would add a cycle the bus cannot absorb. The controller
    // must have released the lanes before a read beat reaches them.
    assign lanes_oe = drive_reg && !output_enable_n && !sleep_reg;

    // Data and parity pins are plain register slices; they carry stale
    // words while undriven, which is harmless behind the drive enable
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            data_out[i*`SRAM_BYTE_W +: `SRAM_BYTE_W] = out_reg[i*LANE_W +: `SRAM_BYTE_W];
            parity_lanes_out[i] = out_reg[i*LANE_W + `SRAM_BYTE_W];
        end
    end

    assign asleep = sleep_reg;

endmodule
